/* design/diwc_pkg.sv */
// Register map, field positions, reset values and timing counts for the line-interface control block
package diwc_pkg;
  // Register indices and their byte addresses on the word-wide bus
  localparam logic [7:0] DIWC_IDX_GENERAL_CONTROL = 8'h02;
  localparam logic [7:0] DIWC_IDX_EVENT_MASK = 8'h03;
  localparam logic [7:0] DIWC_IDX_EVENT_FLAGS = 8'h04;
  localparam logic [7:0] DIWC_IDX_HOOK_CONTROL = 8'h05;
  localparam logic [7:0] DIWC_ADDR_GENERAL_CONTROL = DIWC_IDX_GENERAL_CONTROL << 2;
  localparam logic [7:0] DIWC_ADDR_EVENT_MASK = DIWC_IDX_EVENT_MASK << 2;
  localparam logic [7:0] DIWC_ADDR_EVENT_FLAGS = DIWC_IDX_EVENT_FLAGS << 2;
  localparam logic [7:0] DIWC_ADDR_HOOK_CONTROL = DIWC_IDX_HOOK_CONTROL << 2;

  // General control fields
  localparam int DIWC_GC_PIN_SEL = 7;
  localparam int DIWC_GC_POLARITY = 6;
  localparam int DIWC_GC_WDT_ARM = 4;
  localparam int DIWC_GC_RING_BOTH = 2;
  localparam int DIWC_GC_HYBRID = 1;
  localparam int DIWC_GC_RX_ON = 0;
  localparam logic [7:0] DIWC_GC_WRITABLE = 8'hD7;

  // Event bit positions, shared by mask and flags
  localparam int DIWC_EV_RING = 7;
  localparam int DIWC_EV_RX_OVL = 6;
  localparam int DIWC_EV_FRAME = 5;
  localparam int DIWC_EV_BILLING = 4;
  localparam int DIWC_EV_DROPOUT = 3;
  localparam int DIWC_EV_LOOP_SAT = 2;
  localparam int DIWC_EV_TIP_GND = 1;
  localparam int DIWC_EV_POLARITY = 0;

  // Hook control field
  localparam int DIWC_HK_OFFHOOK = 0;

  // Reset values
  localparam logic [7:0] DIWC_RST_GENERAL_CONTROL = 8'h00;
  localparam logic [7:0] DIWC_RST_EVENT_MASK = 8'h00;
  localparam logic [7:0] DIWC_RST_EVENT_FLAGS = 8'h00;
  localparam logic DIWC_RST_OFFHOOK = 1'b0;

  // Timing
  localparam longint DIWC_CLK_HZ = 20000000;
  localparam longint DIWC_WDT_TIME_S = 4;
  localparam int unsigned DIWC_WDT_CYCLES = 32'(DIWC_WDT_TIME_S * DIWC_CLK_HZ);

  // Bus responses
  localparam logic [1:0] DIWC_RESP_OKAY = 2'h0;
  localparam logic [1:0] DIWC_RESP_SLVERR = 2'h2;
endpackage

/* design/diwc_top.sv */
// Line-interface control, event masking, interrupt pin and register-access watchdog
//
// What this block does
// [RL1] Pin select 0 routes call-progress signal to the shared pin; 1 makes it interrupt.
// [RL2] In interrupt mode, polarity 0 drives active low, polarity 1 active high.
// [RL3] Watchdog arm bit, once set, ignores writes of 0; only reset clears it.
// [RL4] Armed watchdog with no register access for 4 s clears the off-hook bit.
// [RL5] Every register read or write restarts the watchdog count from zero.
// [RL6] After a timeout, writing off-hook to 1 puts the line off-hook again.
// [RL7] Ring mode 0: one ring flag per burst, raised at the burst start.
// [RL8] Ring mode 1: ring flag raised at burst start and again at burst end.
// [RL9] Software must clear the ring flag before burst end to see the second.
// [RL10] Hybrid connect bit 1 inserts the hybrid into transmit; 0 removes it.
// [RL11] Receive path is off while the receive enable bit is 0, on at 1.
// [RL12] Ring event reaches the interrupt only with mask bit 7 set.
// [RL13] Receive overload reaches the interrupt only with mask bit 6 set.
// [RL14] Frame lock loss reaches the interrupt only with mask bit 5 set.
// [RL15] Billing tone reaches the interrupt only with mask bit 4 set.
// [RL16] Supply dropout reaches the interrupt only with mask bit 3 set.
// [RL17] Loop current level all ones raises an event gated by mask bit 2.
// [RL18] Tip ground becoming active reaches the interrupt only with mask bit 1 set.
// [RL19] Any change of line voltage bit 7 is a polarity event, gated by bit 0.
// [RL20] Events drive the interrupt only when masked in and pin is in interrupt mode.
// [RL21] Event flags stay set until software writes 0; the write clears them.
// [RL22] General control bits 5 and 3 ignore writes and read as zero.
// [RL23] Interrupt level is OR of flag-and-mask pairs, polarity applied, held until cleared.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module diwc_top
  import diwc_pkg::*;
#(
  parameter int unsigned WDT_CYCLES = DIWC_WDT_CYCLES,
  parameter int LCL_W = 5
) (
  input wire logic aclk, // System clock, 20 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic ring_active, // High during a ring burst
  input wire logic rx_overload, // Receive input overload level
  input wire logic frame_unlocked, // Isolation link has no frame lock
  input wire logic billing_tone, // Billing tone detected
  input wire logic supply_dropout, // Line-side supply collapsed
  input wire logic [LCL_W-1:0] loop_current_level, // Loop current level field
  input wire logic tip_ground_status, // Tip ground active
  input wire logic line_voltage_msb, // Bit 7 of line voltage level
  input wire logic callprog_in, // Call-progress monitor stream
  output logic callprog_or_irq_pin, // Shared call-progress / interrupt pin
  output logic offhook_ctl, // Line interface off-hook
  output logic hybrid_connect, // Hybrid in transmit path
  output logic rx_path_on, // Receive path enabled
  output logic watchdog_timeout // Pulse when the watchdog fires
);

  localparam int WDT_W = $clog2(WDT_CYCLES + 1);

  logic [7:0] gen_ctl_r;
  logic [7:0] gen_ctl_nxt;
  logic [7:0] mask_r;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic offhook_r;
  logic [WDT_W-1:0] wdt_cnt_r;
  logic [7:0] lvl_prev_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic pin_r;
  logic wdt_fire_r;

  // Write channel: address and data taken together, one response at a time
  wire wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  wire lane0 = s_axi_wstrb[0];
  wire wr_gc = wr_take && lane0 && (s_axi_awaddr == DIWC_ADDR_GENERAL_CONTROL);
  wire wr_mask = wr_take && lane0 && (s_axi_awaddr == DIWC_ADDR_EVENT_MASK);
  wire wr_flags = wr_take && lane0 && (s_axi_awaddr == DIWC_ADDR_EVENT_FLAGS);
  wire wr_hook = wr_take && lane0 && (s_axi_awaddr == DIWC_ADDR_HOOK_CONTROL);
  wire wr_hit = (s_axi_awaddr == DIWC_ADDR_GENERAL_CONTROL) || (s_axi_awaddr == DIWC_ADDR_EVENT_MASK)
             || (s_axi_awaddr == DIWC_ADDR_EVENT_FLAGS) || (s_axi_awaddr == DIWC_ADDR_HOOK_CONTROL);
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Read channel: one read in flight, data registered
  wire rd_take = s_axi_arvalid && !rvalid_r;
  assign s_axi_arready = rd_take;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // Any accepted access, even to an unmapped address, feeds the watchdog
  wire reg_access = wr_take || rd_take;

  // Control field decode
  wire pin_sel = gen_ctl_r[DIWC_GC_PIN_SEL];
  wire irq_pol = gen_ctl_r[DIWC_GC_POLARITY];
  wire wdt_arm = gen_ctl_r[DIWC_GC_WDT_ARM];
  wire ring_both = gen_ctl_r[DIWC_GC_RING_BOTH];
  assign hybrid_connect = gen_ctl_r[DIWC_GC_HYBRID]; // [RL10]
  assign rx_path_on = gen_ctl_r[DIWC_GC_RX_ON]; // [RL11]
  assign offhook_ctl = offhook_r;
  assign callprog_or_irq_pin = pin_r;

  // Reserved bits never stored; arm bit can only be set by software
  always_comb begin
    gen_ctl_nxt = gen_ctl_r;
    if (wr_gc) begin
      gen_ctl_nxt = s_axi_wdata[7:0] & DIWC_GC_WRITABLE; // [RL22]
      gen_ctl_nxt[DIWC_GC_WDT_ARM] = wdt_arm | s_axi_wdata[DIWC_GC_WDT_ARM]; // [RL3]
    end
  end

  // Event sources; levels are tracked so a steady level raises one flag
  wire loop_sat = &loop_current_level; // [RL17]
  wire [7:0] lvl_now = {ring_active, rx_overload, frame_unlocked, billing_tone,
                        supply_dropout, loop_sat, tip_ground_status, line_voltage_msb};
  wire [7:0] rise = lvl_now & ~lvl_prev_r;
  wire ring_fall = lvl_prev_r[DIWC_EV_RING] && !ring_active;
  wire pol_flip = lvl_now[DIWC_EV_POLARITY] ^ lvl_prev_r[DIWC_EV_POLARITY]; // [RL19]
  wire [7:0] ev_set = {rise[DIWC_EV_RING] | (ring_both & ring_fall), // [RL7] [RL8]
                       rise[6:1], pol_flip}; // [RL13] [RL14] [RL15] [RL16] [RL17] [RL18]

  // Set wins over a clearing write landing in the same cycle
  always_comb begin
    flags_nxt = flags_r;
    if (wr_flags) begin
      flags_nxt = flags_r & s_axi_wdata[7:0]; // [RL21]
    end
    flags_nxt = flags_nxt | ev_set;
  end

  // Interrupt level: masked flags, then pin mode and polarity
  wire [7:0] flag_hits = flags_r & mask_r; // [RL12] [RL13] [RL14] [RL15] [RL16] [RL17] [RL18] [RL19]
  wire irq_any = |flag_hits; // [RL23]
  wire irq_level = irq_pol ? irq_any : !irq_any; // [RL2]
  wire pin_nxt = pin_sel ? irq_level : callprog_in; // [RL1] [RL20]

  // Watchdog: counts idle cycles while armed
  wire wdt_hit = wdt_arm && !reg_access && (wdt_cnt_r == WDT_W'(WDT_CYCLES - 1)); // [RL4]
  assign watchdog_timeout = wdt_fire_r;

  // Pulse taken from a flip-flop so the output is glitch-free; it lines up with the on-hook edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_fire_r <= 1'b0;
    end else begin
      wdt_fire_r <= wdt_hit; // [RL4]
    end
  end

  // Register file and event state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_ctl_r <= DIWC_RST_GENERAL_CONTROL;
      mask_r <= DIWC_RST_EVENT_MASK;
      flags_r <= DIWC_RST_EVENT_FLAGS;
      lvl_prev_r <= 8'h00;
      pin_r <= 1'b0;
    end else begin
      gen_ctl_r <= gen_ctl_nxt;
      if (wr_mask) begin
        mask_r <= s_axi_wdata[7:0];
      end
      flags_r <= flags_nxt;
      lvl_prev_r <= lvl_now;
      pin_r <= pin_nxt;
    end
  end

  // Hook control; a write in the timeout cycle cannot occur since access restarts the count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offhook_r <= DIWC_RST_OFFHOOK;
    end else if (wr_hook) begin
      offhook_r <= s_axi_wdata[DIWC_HK_OFFHOOK]; // [RL6]
    end else if (wdt_hit) begin
      offhook_r <= 1'b0; // [RL4]
    end
  end

  // Watchdog counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_cnt_r <= '0;
    end else if (!wdt_arm || reg_access || wdt_hit) begin
      wdt_cnt_r <= '0; // [RL5]
    end else begin
      wdt_cnt_r <= wdt_cnt_r + WDT_W'(1);
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= DIWC_RESP_OKAY;
    end else if (wr_take) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? DIWC_RESP_OKAY : DIWC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read mux; flags read back their live value
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      DIWC_ADDR_GENERAL_CONTROL: rd_byte = gen_ctl_r; // [RL22]
      DIWC_ADDR_EVENT_MASK: rd_byte = mask_r;
      DIWC_ADDR_EVENT_FLAGS: rd_byte = flags_r;
      DIWC_ADDR_HOOK_CONTROL: rd_byte = {7'h00, offhook_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // Read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= DIWC_RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_hit ? DIWC_RESP_OKAY : DIWC_RESP_SLVERR;
      rdata_r <= {24'h000000, rd_byte};
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Checks on the block's own behaviour
  a_pin_callprog: assert property (@(posedge aclk) disable iff (!aresetn) // [RL1]
    !pin_sel |=> (callprog_or_irq_pin == $past(callprog_in)))
    else $error("pin does not follow call progress");

  a_pin_polarity: assert property (@(posedge aclk) disable iff (!aresetn) // [RL2]
    (pin_sel && irq_any) |=> (callprog_or_irq_pin == $past(irq_pol)))
    else $error("interrupt pin has wrong active level");

  a_arm_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // [RL3]
    wdt_arm |=> wdt_arm)
    else $error("watchdog arm cleared without reset");

  a_wdt_onhook: assert property (@(posedge aclk) disable iff (!aresetn) // [RL4]
    (wdt_arm && !reg_access && wdt_cnt_r == WDT_W'(WDT_CYCLES - 1)) |=> !offhook_ctl ##0 wdt_cnt_r == '0)
    else $error("watchdog timeout did not go on-hook");

  a_wdt_restart: assert property (@(posedge aclk) disable iff (!aresetn) // [RL5]
    reg_access |=> (wdt_cnt_r == '0) ##1 (wdt_cnt_r <= WDT_W'(1)))
    else $error("access did not restart watchdog");

  a_offhook_set: assert property (@(posedge aclk) disable iff (!aresetn) // [RL6]
    (wr_hook && s_axi_wdata[DIWC_HK_OFFHOOK]) |=> offhook_ctl)
    else $error("off-hook write not taken");

  a_ring_start: assert property (@(posedge aclk) disable iff (!aresetn) // [RL7]
    $rose(ring_active) |=> flags_r[DIWC_EV_RING])
    else $error("ring start did not flag");

  a_ring_end: assert property (@(posedge aclk) disable iff (!aresetn) // [RL8]
    (ring_both && ring_fall) |=> flags_r[DIWC_EV_RING])
    else $error("ring end did not flag");

  a_ring_single: assert property (@(posedge aclk) disable iff (!aresetn) // [RL7]
    (!ring_both && !flags_r[DIWC_EV_RING] && !rise[DIWC_EV_RING]) |=> !flags_r[DIWC_EV_RING])
    else $error("ring flag set without burst start");

  a_mask_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [RL20]
    (pin_sel && (flags_r & mask_r) == 8'h00) |=> (callprog_or_irq_pin == !$past(irq_pol)))
    else $error("masked event reached interrupt pin");

  a_polarity_event: assert property (@(posedge aclk) disable iff (!aresetn) // [RL19]
    (line_voltage_msb != lvl_prev_r[DIWC_EV_POLARITY]) |=> flags_r[DIWC_EV_POLARITY])
    else $error("polarity flip not flagged");

  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // [RL21]
    !wr_flags |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
    else $error("event flag dropped without write");

  a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [RL21]
    (wr_flags && ev_set == 8'h00) |=> (flags_r == ($past(flags_r) & $past(s_axi_wdata[7:0]))))
    else $error("flag clear by write failed");

  a_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RL22]
    1'b1 |-> ((gen_ctl_r & ~DIWC_GC_WRITABLE) == 8'h00))
    else $error("reserved control bit set");

  a_irq_held: assert property (@(posedge aclk) disable iff (!aresetn) // [RL23]
    (pin_sel && irq_any && !wr_flags && !wr_mask && !wr_gc) [*2] |-> (callprog_or_irq_pin == irq_pol))
    else $error("interrupt level not held");

  a_hybrid_follow: assert property (@(posedge aclk) disable iff (!aresetn) // [RL10]
    wr_gc |=> (hybrid_connect == $past(s_axi_wdata[DIWC_GC_HYBRID])))
    else $error("hybrid connect does not follow write");

  a_rx_follow: assert property (@(posedge aclk) disable iff (!aresetn) // [RL11]
    wr_gc |=> (rx_path_on == $past(s_axi_wdata[DIWC_GC_RX_ON])))
    else $error("receive enable does not follow write");

  a_wdt_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // [RL4]
    1'b1 |=> (watchdog_timeout == $past(wdt_hit)))
    else $error("timeout pulse out of step");

  a_wdt_idle_count: assert property (@(posedge aclk) disable iff (!aresetn) // [RL4]
    (wdt_arm && !reg_access && !wdt_hit) |=> (wdt_cnt_r == $past(wdt_cnt_r) + WDT_W'(1)))
    else $error("idle cycle not counted");

  a_unarmed_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // [RL4]
    (!wdt_arm && !wr_hook) |=> (offhook_ctl == $past(offhook_ctl)))
    else $error("hook changed while watchdog unarmed");

  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn) // [RL21]
    (ev_set != 8'h00) |=> ((flags_r & $past(ev_set)) == $past(ev_set)))
    else $error("event lost against clearing write");

  a_mask_write: assert property (@(posedge aclk) disable iff (!aresetn) // [RL12]
    wr_mask |=> (mask_r == $past(s_axi_wdata[7:0])))
    else $error("mask write not taken");

  a_gc_read: assert property (@(posedge aclk) disable iff (!aresetn) // [RL22]
    (rd_take && s_axi_araddr == DIWC_ADDR_GENERAL_CONTROL) |=> ((s_axi_rdata[7:0] & ~DIWC_GC_WRITABLE) == 8'h00))
    else $error("reserved control bit read as one");

  a_ovl_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [RL13]
    (rx_overload && !lvl_prev_r[DIWC_EV_RX_OVL]) |=> flags_r[DIWC_EV_RX_OVL])
    else $error("overload not flagged");

  a_frame_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [RL14]
    (frame_unlocked && !lvl_prev_r[DIWC_EV_FRAME]) |=> flags_r[DIWC_EV_FRAME])
    else $error("frame loss not flagged");

  a_billing_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [RL15]
    (billing_tone && !lvl_prev_r[DIWC_EV_BILLING]) |=> flags_r[DIWC_EV_BILLING])
    else $error("billing tone not flagged");

  a_dropout_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [RL16]
    (supply_dropout && !lvl_prev_r[DIWC_EV_DROPOUT]) |=> flags_r[DIWC_EV_DROPOUT])
    else $error("supply dropout not flagged");

  a_loop_sat_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [RL17]
    (loop_sat && !lvl_prev_r[DIWC_EV_LOOP_SAT]) |=> flags_r[DIWC_EV_LOOP_SAT])
    else $error("loop saturation not flagged");

  a_tip_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [RL18]
    (tip_ground_status && !lvl_prev_r[DIWC_EV_TIP_GND]) |=> flags_r[DIWC_EV_TIP_GND])
    else $error("tip ground not flagged");

endmodule

/* dv/diwc_host.sv */
// Host processor model: AXI4-Lite master servicing the control registers
`timescale 1ns/1ps
module diwc_host (
  input wire logic aclk, // Bus clock
  output logic [7:0] s_axi_awaddr, // Write address
  output logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address taken
  output logic [31:0] s_axi_wdata, // Write data
  output logic [3:0] s_axi_wstrb, // Byte strobes
  output logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data taken
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  output logic s_axi_bready, // Write response ready
  output logic [7:0] s_axi_araddr, // Read address
  output logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address taken
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic s_axi_rvalid, // Read data valid
  output logic s_axi_rready // Read data ready
);
  // Quiet bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // One write; payload inverted once taken so a stale value never looks current
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // One read; waits as long as the slave takes, the bench timeout bounds it
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

/* dv/diwc_top_bench.sv */
// Self-checking bench for the line-interface control block
`timescale 1ns/1ps
module diwc_top_bench;
  import diwc_pkg::*;
  localparam int WDT = 64;
  localparam int LCL_W = 5;
  localparam logic [7:0] gc_a = DIWC_ADDR_GENERAL_CONTROL;
  localparam logic [7:0] mk_a = DIWC_ADDR_EVENT_MASK;
  localparam logic [7:0] fl_a = DIWC_ADDR_EVENT_FLAGS;
  localparam logic [7:0] hk_a = DIWC_ADDR_HOOK_CONTROL;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ev;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic ring_active, rx_overload, frame_unlocked, billing_tone, supply_dropout;
  logic [LCL_W-1:0] loop_current_level;
  logic tip_ground_status, line_voltage_msb, callprog_in;
  logic callprog_or_irq_pin, offhook_ctl, hybrid_connect, rx_path_on, watchdog_timeout;
  int errors = 0;
  int total_checks = 0;
  int wdt_pulses = 0;

  // Count timeout pulses as the host would see them
  always @(posedge aclk) begin
    if (watchdog_timeout === 1'b1) begin
      wdt_pulses <= wdt_pulses + 1;
    end
  end

  // Event sources follow one byte laid out like the mask
  assign {ring_active, rx_overload, frame_unlocked, billing_tone, supply_dropout} = ev[7:3];
  assign loop_current_level = {LCL_W{ev[2]}};
  assign {tip_ground_status, line_voltage_msb} = ev[1:0];

  // Short watchdog count keeps the idle test to a few dozen cycles
  diwc_top #(.WDT_CYCLES(WDT), .LCL_W(LCL_W)) dut (.*);
  diwc_host host (.*);

  // 20 MHz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  // Bus helpers; every access must answer OKAY on mapped places
  task automatic wrc(input logic [7:0] a, input logic [31:0] v);
    host.wr(a, v, r);
    chk(r, DIWC_RESP_OKAY, "write resp");
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
    host.rd(a, d, r);
    chk(r, DIWC_RESP_OKAY, "read resp");
    chk(d, exp, msg);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    cyc(4);
    aresetn <= 1'b1;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic t_reset();
    do_reset();
    rdc(gc_a, 32'h0, "control reset");
    rdc(mk_a, 32'h0, "mask reset");
    chk(offhook_ctl, 1'b0, "offhook reset");
    host.rd(8'h40, d, r);
    chk(r, DIWC_RESP_SLVERR, "unmapped resp");
    chk(d, 32'h0, "unmapped data");
    $display("test reset done");
  endtask

  task automatic t_ctrl();
    wrc(gc_a, 32'hFF);
    rdc(gc_a, 32'hD7, "reserved bits");
    chk(hybrid_connect, 1'b1, "hybrid on");
    chk(rx_path_on, 1'b1, "rx on");
    wrc(gc_a, 32'h00);
    rdc(gc_a, 32'h10, "arm sticky");
    chk(hybrid_connect, 1'b0, "hybrid off");
    chk(rx_path_on, 1'b0, "rx off");
    $display("test control done");
  endtask

  // Armed from the control test; accesses must keep the line off-hook
  task automatic t_wdt();
    wrc(hk_a, 32'h1);
    repeat (40) host.rd(gc_a, d, r);
    chk(offhook_ctl, 1'b1, "kept alive");
    chk(wdt_pulses, 0, "no pulse while busy");
    cyc(WDT - 8);
    chk(offhook_ctl, 1'b1, "early timeout");
    cyc(16);
    chk(offhook_ctl, 1'b0, "timeout on-hook");
    chk(wdt_pulses, 1, "one timeout pulse");
    wrc(hk_a, 32'h1);
    cyc(2);
    chk(offhook_ctl, 1'b1, "off-hook again");
    do_reset();
    $display("test watchdog done");
  endtask

  task automatic t_mask();
    int i;
    wrc(gc_a, 32'hC0);
    for (i = 0; i < 8; i++) begin
      ev <= 8'(1 << i);
      cyc(3);
      ev <= 8'h00;
      cyc(3);
      rdc(fl_a, 32'h1 << i, "flag set");
      chk(callprog_or_irq_pin, 1'b0, "masked out");
      wrc(mk_a, 32'h1 << i);
      cyc(3);
      chk(callprog_or_irq_pin, 1'b1, "masked in");
      wrc(fl_a, 32'h0);
      cyc(3);
      chk(callprog_or_irq_pin, 1'b0, "cleared");
      wrc(mk_a, 32'h0);
    end
    $display("test mask done");
  endtask

  task automatic t_pin();
    wrc(mk_a, 32'h80);
    ev <= 8'h80;
    cyc(3);
    ev <= 8'h00;
    cyc(3);
    chk(callprog_or_irq_pin, 1'b1, "active high");
    wrc(gc_a, 32'h80);
    cyc(3);
    chk(callprog_or_irq_pin, 1'b0, "active low");
    wrc(gc_a, 32'h00);
    callprog_in <= 1'b1;
    cyc(3);
    chk(callprog_or_irq_pin, 1'b1, "call progress");
    callprog_in <= 1'b0;
    cyc(3);
    chk(callprog_or_irq_pin, 1'b0, "call progress");
    wrc(fl_a, 32'h0);
    $display("test pin done");
  endtask

  task automatic t_ring(input bit both);
    wrc(gc_a, both ? 32'h04 : 32'h00);
    ev <= 8'h80;
    cyc(3);
    rdc(fl_a, 32'h80, "burst start");
    wrc(fl_a, 32'h0);
    ev <= 8'h00;
    cyc(3);
    rdc(fl_a, both ? 32'h80 : 32'h0, "burst end");
    wrc(fl_a, 32'h0);
    $display("test ring done");
  endtask

  // Main sequence
  initial begin
    aresetn = 1'b0;
    ev = 8'h00;
    callprog_in = 1'b0;
    t_reset();
    t_ctrl();
    t_wdt();
    t_mask();
    t_pin();
    t_ring(1'b0);
    t_ring(1'b1);
    end_of_test();
  end

  // Hang guard, well beyond the roughly 500 cycles the tests need
  initial begin
    cyc(20000);
    errors++;
    $display("mismatch at %0t: timeout", $time);
    end_of_test();
  end
endmodule
